// [pkg/erb_regs.svh]
`ifndef ERB_REGS_SVH
`define ERB_REGS_SVH

// register offsets (byte addresses)
`define ERB_OFS_CFG     4'h0
`define ERB_OFS_LDADDR  4'h4
`define ERB_OFS_LDDATA  4'h8
`define ERB_OFS_STATUS  4'hC

// configuration register fields
`define ERB_CFG_SHAPE_LSB 0
`define ERB_CFG_DUAL      2
`define ERB_CFG_SPLIT     3
`define ERB_CFG_DIN_REG   4
`define ERB_CFG_DOUT_REG  5
`define ERB_CFG_WADDR_REG 6
`define ERB_CFG_WE_REG    7
`define ERB_CFG_RADDR_REG 8
`define ERB_CFG_RE_REG    9
`define ERB_CFG_LOCK      10
`define ERB_CFG_W         10
`define ERB_CFG_RST       10'h3D4

// status register fields
`define ERB_STAT_LOCK     0
`define ERB_STAT_COLL     1

// array geometry
`define ERB_CAP_BITS      4096
`define ERB_ROWS          256
`define ERB_ROW_W         8
`define ERB_WORD_W        16
`define ERB_ADDR_W        11
`define ERB_LANE_W        3
`define ERB_SH_W          4
`define ERB_BUS_AW        4
`define ERB_BUS_DW        32

`endif

// [pkg/erb_pkg.sv]
`include "erb_regs.svh"

package erb_pkg;

    typedef enum logic [1:0] {ERB_W16, ERB_W8, ERB_W4, ERB_W2} erb_shape_t;

    typedef struct packed {
        logic       re_reg;
        logic       raddr_reg;
        logic       we_reg;
        logic       waddr_reg;
        logic       dout_reg;
        logic       din_reg;
        logic       split_clk;
        logic       dual;
        erb_shape_t shape;
    } erb_cfg_t;

    typedef struct packed {
        erb_cfg_t                     cfg;
        logic                         locked;
        logic                         coll;
        logic [`ERB_ROW_W-1:0]        ld_row;
        logic [`ERB_SH_W-1:0]         rd_sh;
        erb_shape_t                   rd_shape;
        logic [`ERB_WORD_W-1:0]       pipe;
        logic [`ERB_WORD_W-1:0]       dout;
        logic [`ERB_BUS_DW-1:0]       rdata;
    } erb_top_st_t;

    function automatic logic [`ERB_WORD_W-1:0] erb_width_mask(erb_shape_t s);
        unique case (s)
            ERB_W16: return 16'hFFFF;
            ERB_W8:  return 16'h00FF;
            ERB_W4:  return 16'h000F;
            ERB_W2:  return 16'h0003;
        endcase
    endfunction

    function automatic logic [`ERB_ROW_W-1:0] erb_row_of(logic [`ERB_ADDR_W-1:0] a,
                                                         erb_shape_t s);
        logic [`ERB_ADDR_W-1:0] t;
        t = a >> s;
        return t[`ERB_ROW_W-1:0];
    endfunction

    function automatic logic [`ERB_SH_W-1:0] erb_shift_of(logic [`ERB_ADDR_W-1:0] a,
                                                          erb_shape_t s);
        logic [`ERB_LANE_W-1:0] l;
        l = a[`ERB_LANE_W-1:0] & ~(3'h7 << s);
        unique case (s)
            ERB_W16: return 4'h0;
            ERB_W8:  return {l[0], 3'h0};
            ERB_W4:  return {l[1:0], 2'h0};
            ERB_W2:  return {l[2:0], 1'h0};
        endcase
    endfunction

endpackage

// [pkg/erb_mem_if.sv]
`timescale 1ns/100ps
`include "erb_regs.svh"

interface erb_mem_if;
    logic                   we;
    logic [`ERB_ROW_W-1:0]  waddr;
    logic [`ERB_WORD_W-1:0] wmask;
    logic [`ERB_WORD_W-1:0] wdata;
    logic                   re;
    logic [`ERB_ROW_W-1:0]  raddr;
    logic [`ERB_WORD_W-1:0] rdata;

    modport ctl (output we, waddr, wmask, wdata, re, raddr, input rdata);
    modport mem (input we, waddr, wmask, wdata, re, raddr, output rdata);
endinterface

// [verilog/erb_opt_stage.sv]
`timescale 1ns/100ps

module erb_opt_stage #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic         bypass,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] v;
    } erb_opt_st_t;

    erb_opt_st_t st_q;
    erb_opt_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (en) begin
            st_d.v = d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = bypass ? d : st_q.v;

    a_bypass_pass: assert property (@(posedge clk) disable iff (!rst_n)
        bypass |-> q == d)
        else $error("bypassed stage does not pass input through");
    a_reg_delay: assert property (@(posedge clk) disable iff (!rst_n)
        (en && !bypass) ##1 !bypass |-> q == $past(d))
        else $error("registered stage lost its sample");
endmodule // erb_opt_stage

// [verilog/erb_mem_array.sv]
`timescale 1ns/100ps
`include "erb_regs.svh"

module erb_mem_array (
    input  wire logic clk,
    input  wire logic rst_n,
    erb_mem_if.mem    mif
);
    typedef struct packed {
        logic [`ERB_WORD_W-1:0] rdata;
    } erb_mem_st_t;

    logic [`ERB_WORD_W-1:0] mem_q [0:`ERB_ROWS-1];
    erb_mem_st_t            st_q;
    erb_mem_st_t            st_d;
    logic [`ERB_WORD_W-1:0] old_word;

    assign old_word = mem_q[mif.raddr];

    // read samples the array before this edge's write lands
    always_comb begin
        st_d = st_q;
        if (mif.re) begin
            st_d.rdata = old_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // 256 rows of 16 bits, lanes merged under the write mask
    always_ff @(posedge clk) begin
        if (mif.we) begin
            mem_q[mif.waddr] <= (mem_q[mif.waddr] & ~mif.wmask)
                              | (mif.wdata & mif.wmask);
        end
    end

    assign mif.rdata = st_q.rdata;

    a_read_old: assert property (@(posedge clk) disable iff (!rst_n)
        (mif.re && mif.we && mif.raddr == mif.waddr) |=> mif.rdata == $past(old_word))
        else $error("colliding read did not return the old word");
endmodule // erb_mem_array

// [verilog/erb_ram_top.sv]
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
`include "erb_regs.svh"

// How it works
// - The array holds 4096 bits, every bit usable in any shape.
// - Shapes: 256x16, 512x8, 1024x4 or 2048x2, chosen in the config register.
// - Single-port mode shares the write address; dual-port has separate read address.
// - Write and read sections run from their own enables, so at separate rates.
// - Outside split clocking, each section's registers advance only when its own clock enable is high.
// - Split clocking: write enable clocks all input stages, read enable clocks outputs.
// - Data in, data out, both addresses and both enables each register or bypass.
// - Every register except the array words resets asynchronously, from reset or the local clear pin; all clear except the config register, which loads 3D4.
// - The write strobe is made inside from the clock; user meets setup only.
// - Lookup use: preload over the bus, lock, then the array is read only.
// - Depth cascading keeps access timing; latency does not depend on shape.
// - The two sections serve as FIFO storage on common or separate enables.
module erb_ram_top
    import erb_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    ce,
    input  wire logic                    clr_n,
    input  wire logic [`ERB_BUS_AW-1:0]  reg_addr,
    input  wire logic [`ERB_BUS_DW-1:0]  reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`ERB_BUS_DW-1:0]  reg_rdata,
    input  wire logic                    wr_ce,
    input  wire logic                    rd_ce,
    input  wire logic [`ERB_WORD_W-1:0]  din,
    input  wire logic [`ERB_ADDR_W-1:0]  wr_addr,
    input  wire logic                    wr_en,
    input  wire logic [`ERB_ADDR_W-1:0]  rd_addr,
    input  wire logic                    rd_en,
    output logic      [`ERB_WORD_W-1:0]  dout
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // clear and section enables

    logic                   rst_n;
    logic                   wr_go;
    logic                   rd_go;
    logic                   rin_en;
    erb_top_st_t            st_q;
    erb_top_st_t            st_d;
    erb_mem_if              mif ();

    assign rst_n = arst_n & clr_n;

    // separate enables stand in for separate section clocks
    assign wr_go  = ce & wr_ce;
    assign rd_go  = ce & rd_ce;
    assign rin_en = st_q.cfg.split_clk ? wr_go : rd_go;

    ////////////////////////////////////////////////////////////////////////////////////////
    // optional input stages

    logic [`ERB_WORD_W-1:0] din_s;
    logic [`ERB_ADDR_W-1:0] wa_s;
    logic                   we_s;
    logic [`ERB_ADDR_W-1:0] ra_s;
    logic                   re_s;

    erb_opt_stage #(.W(`ERB_WORD_W)) u_din (
        .clk    (clk),
        .rst_n  (rst_n),
        .en     (wr_go),
        .bypass (!st_q.cfg.din_reg),
        .d      (din),
        .q      (din_s)
    );

    erb_opt_stage #(.W(`ERB_ADDR_W)) u_waddr (
        .clk    (clk),
        .rst_n  (rst_n),
        .en     (wr_go),
        .bypass (!st_q.cfg.waddr_reg),
        .d      (wr_addr),
        .q      (wa_s)
    );

    erb_opt_stage #(.W(1)) u_we (
        .clk    (clk),
        .rst_n  (rst_n),
        .en     (wr_go),
        .bypass (!st_q.cfg.we_reg),
        .d      (wr_en),
        .q      (we_s)
    );

    erb_opt_stage #(.W(`ERB_ADDR_W)) u_raddr (
        .clk    (clk),
        .rst_n  (rst_n),
        .en     (rin_en),
        .bypass (!st_q.cfg.raddr_reg),
        .d      (rd_addr),
        .q      (ra_s)
    );

    erb_opt_stage #(.W(1)) u_re (
        .clk    (clk),
        .rst_n  (rst_n),
        .en     (rin_en),
        .bypass (!st_q.cfg.re_reg),
        .d      (rd_en),
        .q      (re_s)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // array access

    logic                   bus_load;
    logic                   user_wr;
    logic [`ERB_ADDR_W-1:0] ra_eff;
    logic [`ERB_SH_W-1:0]   wsh;
    logic [`ERB_WORD_W-1:0] wmask_w;
    logic [`ERB_WORD_W-1:0] ext;

    assign bus_load = ce && reg_wr && reg_addr == `ERB_OFS_LDDATA && !st_q.locked;
    assign user_wr  = wr_go && we_s && !st_q.locked;

    // single-port mode reads where it writes
    assign ra_eff  = st_q.cfg.dual ? ra_s : wa_s;
    assign wsh     = erb_shift_of(wa_s, st_q.cfg.shape);
    assign wmask_w = erb_width_mask(st_q.cfg.shape);

    // preload from the bus outranks a user write in the same cycle
    always_comb begin
        mif.we    = bus_load | user_wr;
        mif.waddr = bus_load ? st_q.ld_row : erb_row_of(wa_s, st_q.cfg.shape);
        mif.wmask = bus_load ? 16'hFFFF : (wmask_w << wsh);
        mif.wdata = bus_load ? reg_wdata[`ERB_WORD_W-1:0] : ((din_s & wmask_w) << wsh);
        mif.re    = rd_go & re_s;
        mif.raddr = erb_row_of(ra_eff, st_q.cfg.shape);
    end

    erb_mem_array u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .mif   (mif.mem)
    );

    // lane pick and zero fill of unused upper bits
    assign ext = (mif.rdata >> st_q.rd_sh) & erb_width_mask(st_q.rd_shape);

    ////////////////////////////////////////////////////////////////////////////////////////
    // register file and output path

    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.rdata = '0;
            if (mif.re) begin
                st_d.rd_sh    = erb_shift_of(ra_eff, st_q.cfg.shape);
                st_d.rd_shape = st_q.cfg.shape;
            end
            if (rd_go) begin
                st_d.pipe = ext;
                st_d.dout = st_q.cfg.dout_reg ? st_q.pipe : ext;
            end
            if (reg_wr) begin
                unique case (reg_addr)
                    `ERB_OFS_CFG: begin
                        st_d.cfg = erb_cfg_t'(reg_wdata[`ERB_CFG_W-1:0]);
                        if (reg_wdata[`ERB_CFG_LOCK]) begin
                            st_d.locked = 1'b1;
                        end
                    end
                    `ERB_OFS_LDADDR: st_d.ld_row = reg_wdata[`ERB_ROW_W-1:0];
                    `ERB_OFS_LDDATA: begin
                        if (!st_q.locked) begin
                            st_d.ld_row = st_q.ld_row + 8'h01;
                        end
                    end
                    `ERB_OFS_STATUS: begin
                        if (reg_wdata[`ERB_STAT_COLL]) begin
                            st_d.coll = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
            // set wins over a clear in the same cycle
            if (mif.we && mif.re && mif.waddr == mif.raddr) begin
                st_d.coll = 1'b1;
            end
            if (reg_rd) begin
                unique case (reg_addr)
                    `ERB_OFS_CFG:    st_d.rdata = {21'h0, st_q.locked, st_q.cfg};
                    `ERB_OFS_LDADDR: st_d.rdata = {24'h0, st_q.ld_row};
                    `ERB_OFS_STATUS: st_d.rdata = {30'h0, st_q.coll, st_q.locked};
                    default:         st_d.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= '0;
            st_q.cfg <= erb_cfg_t'(`ERB_CFG_RST);
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign dout      = st_q.dout;

    ////////////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_lock_sticky: assert property (st_q.locked |=> st_q.locked)
        else $error("lookup lock was released without reset");
    a_rom_no_write: assert property (st_q.locked |-> !mif.we)
        else $error("array written while locked");
    a_mask_width: assert property (user_wr && !bus_load |->
        $countones(mif.wmask) == $countones(wmask_w))
        else $error("write mask width disagrees with shape");
    a_coll_set: assert property ((mif.we && mif.re && mif.waddr == mif.raddr) |=> st_q.coll)
        else $error("collision not flagged");
    a_freeze_all: assert property (!ce |=> $stable(dout) && $stable(reg_rdata))
        else $error("state moved while clock enable low");
    a_we_section: assert property (mif.we |-> ce && (wr_ce || bus_load))
        else $error("write strobe outside write section enable");
    a_single_port: assert property (!st_q.cfg.dual && mif.re |->
        mif.raddr == erb_row_of(wa_s, st_q.cfg.shape))
        else $error("single-port read used the read address");
    a_cfg_readback: assert property ((ce && reg_rd && reg_addr == `ERB_OFS_CFG) |=>
        reg_rdata[`ERB_CFG_W-1:0] == $past(st_q.cfg))
        else $error("config read data wrong or late");
    a_split_hold: assert property ((st_q.cfg.split_clk && !wr_go && rd_go && !reg_wr)
        ##1 (st_q.cfg.raddr_reg && st_q.cfg.split_clk) |-> $stable(ra_s))
        else $error("read address stage advanced off the input enable");

    c_collision: cover property (mif.we && mif.re && mif.waddr == mif.raddr);
    c_locked_read: cover property (st_q.locked ##1 mif.re ##2 rd_go);
    c_narrow_write: cover property (user_wr && st_q.cfg.shape == ERB_W2);
    c_split_read: cover property (st_q.cfg.split_clk && mif.re && !wr_ce);
endmodule // erb_ram_top

// [tb/erb_user_model.sv]
`timescale 1ns/100ps
`include "erb_regs.svh"

module erb_user_model (
    input  wire logic                   clk,
    output logic                        wr_ce,
    output logic                        rd_ce,
    output logic [`ERB_WORD_W-1:0]      din,
    output logic [`ERB_ADDR_W-1:0]      wr_addr,
    output logic                        wr_en,
    output logic [`ERB_ADDR_W-1:0]      rd_addr,
    output logic                        rd_en,
    input  wire logic [`ERB_WORD_W-1:0] dout
);
    initial begin
        wr_ce   = 1'b1;
        rd_ce   = 1'b1;
        din     = 16'h0000;
        wr_addr = 11'h000;
        wr_en   = 1'b0;
        rd_addr = 11'h000;
        rd_en   = 1'b0;
    end

    // slow user logic: park either section between edges
    task automatic set_ce(input logic w, input logic r);
        @(posedge clk);
        wr_ce <= w;
        rd_ce <= r;
    endtask

    // one access: one write section and one read section only
    // signals change after an edge and hold one edge, no strobe made here
    // sp routes the read address through the write address path
    task automatic acc(input logic we, input logic [10:0] a, input logic [15:0] d,
                       input logic re, input logic sp, input int n,
                       output logic [15:0] q);
        @(posedge clk);
        wr_en   <= we;
        rd_en   <= re;
        wr_addr <= (we | sp) ? a : ~a; // one address covers every data bit
        rd_addr <= sp ? ~a : a;
        din     <= d;
        @(posedge clk);
        wr_en   <= 1'b0;
        rd_en   <= 1'b0;
        wr_addr <= ~a;
        rd_addr <= ~a;
        din     <= ~d;
        repeat (n - 1) @(posedge clk);
        #1 q = dout;
    endtask
endmodule // erb_user_model

// [tb/testbench.sv]
`timescale 1ns/100ps
`include "erb_regs.svh"

module testbench;
    logic        clk;
    logic        arst_n;
    logic        ce;
    logic        clr_n;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        wr_ce;
    logic        rd_ce;
    logic [15:0] din;
    logic [10:0] wr_addr;
    logic        wr_en;
    logic [10:0] rd_addr;
    logic        rd_en;
    logic [15:0] dout;
    logic [15:0] q;
    int          mismatches;
    int          num_checks;

    erb_ram_top dut (.clk(clk), .arst_n(arst_n), .ce(ce), .clr_n(clr_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wr_ce(wr_ce), .rd_ce(rd_ce), .din(din),
        .wr_addr(wr_addr), .wr_en(wr_en), .rd_addr(rd_addr), .rd_en(rd_en), .dout(dout));

    erb_user_model u_user (.clk(clk), .wr_ce(wr_ce), .rd_ce(rd_ce), .din(din),
        .wr_addr(wr_addr), .wr_en(wr_en), .rd_addr(rd_addr), .rd_en(rd_en), .dout(dout));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk_reg(reg_rdata, exp, "register read");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        reg_read(`ERB_OFS_CFG, 32'h0000_03D4);
        reg_read(`ERB_OFS_STATUS, 32'h0000_0000);
        reg_read(4'h2, 32'h0000_0000);
    endtask

    task automatic t_default_latency;
        u_user.acc(1'b1, 11'h003, 16'h1357, 1'b0, 1'b0, 1, q);
        u_user.acc(1'b0, 11'h003, 16'h0000, 1'b1, 1'b0, 3, q);
        chk_word(q, 16'h1357, "registered read");
    endtask

    task automatic t_shapes;
        logic [15:0] mask;
        logic [10:0] top;
        for (int s = 0; s < 4; s++) begin
            reg_write(`ERB_OFS_CFG, 32'h0000_0004 | s);
            mask = 16'hFFFF >> (16 - (16 >> s));
            top  = 11'((256 << s) - 1);
            u_user.acc(1'b1, 11'h000, 16'hA5C3, 1'b0, 1'b0, 1, q);
            u_user.acc(1'b1, 11'h001, 16'h5A3C, 1'b0, 1'b0, 1, q);
            u_user.acc(1'b1, top, 16'hC3A5, 1'b0, 1'b0, 1, q);
            u_user.acc(1'b0, 11'h000, 16'h0000, 1'b1, 1'b0, 2, q);
            chk_word(q, 16'hA5C3 & mask, "lane 0");
            u_user.acc(1'b0, 11'h001, 16'h0000, 1'b1, 1'b0, 2, q);
            chk_word(q, 16'h5A3C & mask, "lane 1");
            u_user.acc(1'b0, top, 16'h0000, 1'b1, 1'b0, 2, q);
            chk_word(q, 16'hC3A5 & mask, "top word");
        end
    endtask

    task automatic t_single;
        reg_write(`ERB_OFS_CFG, 32'h0000_0000);
        u_user.acc(1'b1, 11'h007, 16'h0F0F, 1'b0, 1'b1, 1, q);
        u_user.acc(1'b0, 11'h007, 16'h0000, 1'b1, 1'b1, 2, q);
        chk_word(q, 16'h0F0F, "single port read");
    endtask

    task automatic t_collision;
        reg_write(`ERB_OFS_CFG, 32'h0000_0004);
        u_user.acc(1'b1, 11'h005, 16'h1234, 1'b0, 1'b0, 1, q);
        u_user.acc(1'b1, 11'h005, 16'hABCD, 1'b1, 1'b0, 2, q);
        chk_word(q, 16'h1234, "old word");
        u_user.acc(1'b0, 11'h005, 16'h0000, 1'b1, 1'b0, 2, q);
        chk_word(q, 16'hABCD, "new word");
        reg_read(`ERB_OFS_STATUS, 32'h0000_0002);
        reg_write(`ERB_OFS_STATUS, 32'h0000_0002);
        reg_read(`ERB_OFS_STATUS, 32'h0000_0000);
    endtask

    task automatic t_stall;
        u_user.set_ce(1'b1, 1'b0);
        u_user.acc(1'b0, 11'h007, 16'h0000, 1'b1, 1'b0, 2, q);
        chk_word(q, 16'hABCD, "read parked");
        u_user.set_ce(1'b0, 1'b1);
        u_user.acc(1'b1, 11'h005, 16'h0000, 1'b0, 1'b0, 1, q);
        u_user.set_ce(1'b1, 1'b1);
        u_user.acc(1'b0, 11'h005, 16'h0000, 1'b1, 1'b0, 2, q);
        chk_word(q, 16'hABCD, "write parked");
        @(posedge clk);
        ce <= 1'b0;
        u_user.acc(1'b1, 11'h005, 16'h0F0F, 1'b0, 1'b0, 1, q);
        u_user.acc(1'b0, 11'h007, 16'h0000, 1'b1, 1'b0, 2, q);
        chk_word(q, 16'hABCD, "read frozen");
        @(posedge clk);
        ce <= 1'b1;
        u_user.acc(1'b0, 11'h005, 16'h0000, 1'b1, 1'b0, 2, q);
        chk_word(q, 16'hABCD, "write frozen");
    endtask

    task automatic t_split;
        reg_write(`ERB_OFS_CFG, 32'h0000_03FC);
        u_user.acc(1'b1, 11'h009, 16'h2468, 1'b0, 1'b0, 1, q);
        u_user.acc(1'b0, 11'h009, 16'h0000, 1'b1, 1'b0, 4, q);
        chk_word(q, 16'h2468, "all stages registered");
        u_user.set_ce(1'b0, 1'b1);
        u_user.acc(1'b0, 11'h007, 16'h0000, 1'b1, 1'b0, 4, q);
        chk_word(q, 16'h2468, "read input parked");
        u_user.set_ce(1'b1, 1'b1);
    endtask

    task automatic t_lock;
        reg_write(`ERB_OFS_LDADDR, 32'h0000_0010);
        reg_write(`ERB_OFS_LDDATA, 32'h0000_BEEF);
        reg_write(`ERB_OFS_LDDATA, 32'h0000_1234);
        reg_write(`ERB_OFS_CFG, 32'h0000_0404);
        reg_read(`ERB_OFS_CFG, 32'h0000_0404);
        reg_read(`ERB_OFS_STATUS, 32'h0000_0001);
        u_user.acc(1'b1, 11'h010, 16'h0000, 1'b0, 1'b0, 1, q);
        u_user.acc(1'b0, 11'h010, 16'h0000, 1'b1, 1'b0, 2, q);
        chk_word(q, 16'hBEEF, "table row");
        u_user.acc(1'b0, 11'h011, 16'h0000, 1'b1, 1'b0, 2, q);
        chk_word(q, 16'h1234, "next row");
    endtask

    task automatic t_clear;
        @(posedge clk);
        clr_n <= 1'b0;
        repeat (2) @(posedge clk);
        clr_n <= 1'b1;
        reg_read(`ERB_OFS_CFG, 32'h0000_03D4);
        reg_read(`ERB_OFS_STATUS, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict;
    end

    initial begin
        mismatches = 0;
        num_checks = 0;
        arst_n     = 1'b0;
        ce         = 1'b1;
        clr_n      = 1'b1;
        reg_addr   = 4'h0;
        reg_wdata  = 32'h0000_0000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_default_latency;
        t_shapes;
        t_single;
        t_collision;
        t_stall;
        t_split;
        t_lock;
        t_clear;
        print_verdict;
    end
endmodule // testbench
